// ---- rtl/lockin_settings_pkg.sv ----
// Constants, encodings and helper functions for the settings decoder.
package lockin_settings_pkg;

   // Register port widths.
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // Register byte addresses.
   localparam logic [7:0] OUTPUT_ENABLE_ADDR = 8'h00;
   localparam logic [7:0] REFERENCE_SOURCE_ADDR = 8'h04;
   localparam logic [7:0] FIRST_RESERVE_ADDR = 8'h08;
   localparam logic [7:0] SECOND_RESERVE_ADDR = 8'h0C;
   localparam logic [7:0] FIRST_AVERAGE_ADDR = 8'h10;
   localparam logic [7:0] FIRST_SLOPE_ADDR = 8'h14;
   localparam logic [7:0] STATUS_ADDR = 8'h18;

   // Field positions.
   localparam int FIRST_OUT_BIT = 0;
   localparam int SECOND_OUT_BIT = 1;
   localparam int REF_BIT = 0;
   localparam int RESERVE_LSB = 0;
   localparam int MANT_W = 28;
   localparam int MANT_LSB = 0;
   localparam int SUFFIX_LSB = 28;
   localparam int KIND_LSB = 30;
   localparam int SLOPE_LSB = 0;
   localparam int REJECT_BIT = 0;

   // Reference source choices.
   typedef enum logic {
      external_reference_choice = 1'h0,
      internal_oscillator_choice = 1'h1
   } ref_source_t;

   // Dynamic reserve levels, highest reserve first.
   typedef enum logic [1:0] {
      reserve_level_high = 2'h0,
      reserve_level_medium = 2'h1,
      reserve_level_low = 2'h2,
      reserve_level_lower = 2'h3
   } reserve_t;

   // Averaging time write kinds; code 3 is refused.
   typedef enum logic [1:0] {
      avg_kind_off = 2'h0,
      avg_kind_auto = 2'h1,
      avg_kind_time = 2'h2,
      avg_kind_bad = 2'h3
   } avg_kind_t;

   // Multiplier suffixes; code 3 is refused.
   typedef enum logic [1:0] {
      suffix_seconds = 2'h0,
      suffix_milli = 2'h1,
      suffix_micro = 2'h2,
      suffix_bad = 2'h3
   } suffix_t;

   // Averaging time tokens: off, auto, then the 1-2-5 steps from 1 us.
   localparam int STEP_IDX_W = 5;
   localparam int STEP_COUNT = 25;
   localparam int DECADES = 8;
   localparam logic [4:0] AVG_CODE_OFF = 5'h00;
   localparam logic [4:0] AVG_CODE_AUTO = 5'h01;
   localparam logic [4:0] AVG_CODE_STEP0 = 5'h02;
   localparam logic [4:0] AVG_CODE_MAX = 5'h1A;
   localparam logic [4:0] AVG_CODE_1MS = 5'h0B;

   // Scale factors into microseconds.
   localparam logic [47:0] US_PER_US = 48'h000000000001;
   localparam logic [47:0] US_PER_MS = 48'h0000000003E8;
   localparam logic [47:0] US_PER_S = 48'h0000000F4240;
   localparam logic [47:0] DECADE_FACTOR = 48'h00000000000A;
   localparam logic [47:0] FIVE_FACTOR = 48'h000000000005;

   // Filter slopes in dB per octave.
   localparam logic [7:0] SLOPE_6DB = 8'h06;
   localparam logic [7:0] SLOPE_12DB = 8'h0C;
   localparam logic [7:0] SLOPE_18DB = 8'h12;
   localparam logic [7:0] SLOPE_24DB = 8'h18;

   // Reset values.
   localparam logic [1:0] OUT_ENABLE_RESET = 2'h0;
   localparam ref_source_t REF_RESET = internal_oscillator_choice;
   localparam reserve_t RESERVE_RESET = reserve_level_medium;
   localparam logic [4:0] AVG_RESET = AVG_CODE_OFF;
   localparam logic [7:0] SLOPE_RESET = SLOPE_24DB;

   // Length of step idx in microseconds: digit 1, 2 or 5 times a power of ten.
   function automatic logic [47:0] step_us(input logic [4:0] idx);
      logic [47:0] p;
      int decade;
      p = US_PER_US;
      decade = int'(idx) / 3;
      for (int i = 0; i < DECADES + 1; i++) begin
         if (i < decade) begin
            p = p * DECADE_FACTOR;
         end
      end
      unique case (int'(idx) % 3)
         0: step_us = p;
         1: step_us = p << 1;
         default: step_us = p * FIVE_FACTOR;
      endcase
   endfunction

   // True for one of the four accepted slopes.
   function automatic logic legal_slope(input logic [7:0] v);
      legal_slope = (v == SLOPE_6DB) || (v == SLOPE_12DB) ||
         (v == SLOPE_18DB) || (v == SLOPE_24DB);
   endfunction

endpackage

// ---- rtl/avg_round_if.sv ----
// Carries an averaging time value to the rounder and the step back.
`timescale 1ns/10ps
`default_nettype none
interface avg_round_if;
   logic [27:0] mantissa;
   logic [1:0] suffix;
   logic [4:0] step_idx;

   // The decoder offers a value, the rounder returns the step.
   modport requester (output mantissa, output suffix, input step_idx);
   modport rounder (input mantissa, input suffix, output step_idx);
endinterface
`default_nettype wire

// ---- rtl/average_time_rounder.sv ----
// Scales an averaging time to microseconds and rounds it to the nearest step.
`timescale 1ns/10ps
`default_nettype none
module average_time_rounder
   import lockin_settings_pkg::*;
(
   // Value in, step out.
   avg_round_if.rounder rnd
);
   logic [47:0] scale;
   logic [47:0] scaled_us;
   logic [4:0] idx;

   // Apply the micro or milli multiplier; bare numbers are seconds.
   always_comb begin
      unique case (rnd.suffix)
         suffix_micro: scale = US_PER_US;
         suffix_milli: scale = US_PER_MS;
         default: scale = US_PER_S;
      endcase
      scaled_us = {20'h00000, rnd.mantissa} * scale;
   end

   // Count the midpoints at or below the value; ties go to the longer step.
   always_comb begin
      idx = 5'h00;
      for (int k = 0; k < STEP_COUNT - 1; k++) begin
         if ({scaled_us, 1'b0} >= ({1'b0, step_us(5'(k))} + {1'b0, step_us(5'(k + 1))})) begin
            idx = 5'(k + 1);
         end
      end
   end

   assign rnd.step_idx = idx;
endmodule
`default_nettype wire

// ---- rtl/lockin_setting_command_decoder.sv ----
// Settings decoder: holds and reports output, reference, reserve and filter settings.
//
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module lockin_setting_command_decoder
   import lockin_settings_pkg::*;
(
   // Clock and reset.
   input wire logic core_clk,
   input wire logic sys_rst,
   // Register port.
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Settings toward the front end.
   output logic first_data_output_pin_en,
   output logic second_data_output_pin_en,
   output logic reference_source,
   output logic [1:0] first_reserve,
   output logic [1:0] second_reserve,
   output logic [4:0] first_average_code,
   output logic [7:0] first_filter_slope,
   output logic write_rejected
);

   logic first_en;
   logic second_en;
   ref_source_t ref_src;
   reserve_t res1;
   reserve_t res2;
   logic [4:0] avg_code;
   logic [7:0] slope;
   logic reject;
   logic [31:0] rdata;
   logic next_first_en;
   logic next_second_en;
   ref_source_t next_ref_src;
   reserve_t next_res1;
   reserve_t next_res2;
   logic [4:0] next_avg_code;
   logic [7:0] next_slope;
   logic next_reject;
   logic [31:0] next_rdata;
   avg_kind_t wr_kind;
   suffix_t wr_suffix;
   logic [7:0] wr_slope;
   logic bad_write;

   avg_round_if round_bus ();

   // Offer the written averaging time to the rounder.
   assign round_bus.mantissa = reg_wdata[MANT_LSB +: MANT_W];
   assign round_bus.suffix = reg_wdata[SUFFIX_LSB +: 2];

   average_time_rounder u_rounder (
      .rnd(round_bus.rounder)
   );

   // Decode the write data fields.
   assign wr_kind = avg_kind_t'(reg_wdata[KIND_LSB +: 2]);
   assign wr_suffix = suffix_t'(reg_wdata[SUFFIX_LSB +: 2]);
   assign wr_slope = reg_wdata[SLOPE_LSB +: 8];

   // Next settings: a valid write replaces a setting, anything else holds it.
   always_comb begin
      next_first_en = first_en;
      next_second_en = second_en;
      next_ref_src = ref_src;
      next_res1 = res1;
      next_res2 = res2;
      next_avg_code = avg_code;
      next_slope = slope;
      bad_write = 1'b0;
      if (reg_wr) begin
         unique case (reg_addr)
            OUTPUT_ENABLE_ADDR: begin
               next_first_en = reg_wdata[FIRST_OUT_BIT];
               next_second_en = reg_wdata[SECOND_OUT_BIT];
            end
            REFERENCE_SOURCE_ADDR: begin
               next_ref_src = ref_source_t'(reg_wdata[REF_BIT]);
            end
            FIRST_RESERVE_ADDR: begin
               next_res1 = reserve_t'(reg_wdata[RESERVE_LSB +: 2]);
            end
            SECOND_RESERVE_ADDR: begin
               next_res2 = reserve_t'(reg_wdata[RESERVE_LSB +: 2]);
            end
            FIRST_AVERAGE_ADDR: begin
               unique case (wr_kind)
                  avg_kind_off: next_avg_code = AVG_CODE_OFF;
                  avg_kind_auto: next_avg_code = AVG_CODE_AUTO;
                  avg_kind_time: begin
                     if (wr_suffix == suffix_bad) begin
                        bad_write = 1'b1;
                     end else begin
                        next_avg_code = AVG_CODE_STEP0 + round_bus.step_idx;
                     end
                  end
                  default: bad_write = 1'b1;
               endcase
            end
            FIRST_SLOPE_ADDR: begin
               if (legal_slope(wr_slope)) begin
                  next_slope = wr_slope;
               end else begin
                  bad_write = 1'b1;
               end
            end
            default: begin
               bad_write = 1'b0;
            end
         endcase
      end
   end

   // Refused writes raise a sticky flag; a new refusal beats a clear in the same cycle.
   always_comb begin
      next_reject = reject;
      if (reg_wr && reg_addr == STATUS_ADDR && reg_wdata[REJECT_BIT]) begin
         next_reject = 1'b0;
      end
      if (bad_write) begin
         next_reject = 1'b1;
      end
   end

   // Read data for the cycle after the read strobe; unmapped addresses read zero.
   always_comb begin
      next_rdata = 32'h00000000;
      if (reg_rd) begin
         unique case (reg_addr)
            OUTPUT_ENABLE_ADDR: begin
               next_rdata[FIRST_OUT_BIT] = first_en;
               next_rdata[SECOND_OUT_BIT] = second_en;
            end
            REFERENCE_SOURCE_ADDR: next_rdata[REF_BIT] = ref_src;
            FIRST_RESERVE_ADDR: next_rdata[RESERVE_LSB +: 2] = res1;
            SECOND_RESERVE_ADDR: next_rdata[RESERVE_LSB +: 2] = res2;
            FIRST_AVERAGE_ADDR: next_rdata[4:0] = avg_code;
            FIRST_SLOPE_ADDR: next_rdata[SLOPE_LSB +: 8] = slope;
            STATUS_ADDR: next_rdata[REJECT_BIT] = reject;
            default: next_rdata = 32'h00000000;
         endcase
      end
   end

   // Register all state; reset restores the defaults.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         first_en <= OUT_ENABLE_RESET[FIRST_OUT_BIT];
         second_en <= OUT_ENABLE_RESET[SECOND_OUT_BIT];
         ref_src <= REF_RESET;
         res1 <= RESERVE_RESET;
         res2 <= RESERVE_RESET;
         avg_code <= AVG_RESET;
         slope <= SLOPE_RESET;
         reject <= 1'b0;
         rdata <= 32'h00000000;
      end else begin
         first_en <= next_first_en;
         second_en <= next_second_en;
         ref_src <= next_ref_src;
         res1 <= next_res1;
         res2 <= next_res2;
         avg_code <= next_avg_code;
         slope <= next_slope;
         reject <= next_reject;
         rdata <= next_rdata;
      end
   end

   // Settings leave the block straight from their flip-flops.
   assign first_data_output_pin_en = first_en;
   assign second_data_output_pin_en = second_en;
   assign reference_source = ref_src;
   assign first_reserve = res1;
   assign second_reserve = res2;
   assign first_average_code = avg_code;
   assign first_filter_slope = slope;
   assign write_rejected = reject;
   assign reg_rdata = rdata;

   // Checks on the settings behaviour.
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   out1_write_a: assert property (
      reg_wr && reg_addr == OUTPUT_ENABLE_ADDR |=>
         first_data_output_pin_en == $past(reg_wdata[FIRST_OUT_BIT]))
      else $error("first output enable did not follow the write");

   out2_readback_a: assert property (
      reg_rd && reg_addr == OUTPUT_ENABLE_ADDR && !reg_wr |=>
         reg_rdata[SECOND_OUT_BIT] == second_data_output_pin_en && reg_rdata[31:2] == 30'h0)
      else $error("second output enable read back wrong");

   ref_source_write_a: assert property (
      reg_wr && reg_addr == REFERENCE_SOURCE_ADDR |=>
         reference_source == $past(reg_wdata[REF_BIT]) ##1 $stable(reference_source) || $past(reg_wr))
      else $error("reference source did not take the written choice");

   reserve_one_set_a: assert property (
      reg_wr && reg_addr == FIRST_RESERVE_ADDR |=>
         first_reserve == $past(reg_wdata[1:0]) && $stable(second_reserve))
      else $error("first reserve write wrong or disturbed the second");

   reserve_two_set_a: assert property (
      reg_wr && reg_addr == SECOND_RESERVE_ADDR |=>
         second_reserve == $past(reg_wdata[1:0]) && $stable(first_reserve))
      else $error("second reserve write wrong or disturbed the first");

   avg_range_a: assert property (
      first_average_code <= AVG_CODE_MAX)
      else $error("averaging token out of range");

   avg_round_a: assert property (
      reg_wr && reg_addr == FIRST_AVERAGE_ADDR && wr_kind == avg_kind_time &&
         wr_suffix != suffix_bad |=>
         first_average_code == AVG_CODE_STEP0 + $past(round_bus.step_idx))
      else $error("averaging time not stored as the rounded step");

   avg_suffix_a: assert property (
      reg_wr && reg_addr == FIRST_AVERAGE_ADDR && wr_kind == avg_kind_time &&
         wr_suffix == suffix_micro && reg_wdata[27:0] == 28'h00003E8 |=>
         first_average_code == AVG_CODE_1MS)
      else $error("micro suffix not scaled to one millisecond");

   slope_legal_a: assert property (
      reg_wr && reg_addr == FIRST_SLOPE_ADDR && !legal_slope(wr_slope) |=>
         $stable(first_filter_slope) && write_rejected)
      else $error("illegal slope was stored or not flagged");

   read_no_change_a: assert property (
      reg_rd |=> $stable(first_data_output_pin_en) && $stable(second_data_output_pin_en) &&
         $stable(first_reserve) && $stable(second_reserve) &&
         $stable(first_average_code) && $stable(first_filter_slope))
      else $error("a read changed a setting");

   out1_readback_a: assert property (
      reg_rd && reg_addr == OUTPUT_ENABLE_ADDR |=>
         reg_rdata[FIRST_OUT_BIT] == first_data_output_pin_en)
      else $error("first output enable read back wrong");

   out2_write_a: assert property (
      reg_wr && reg_addr == OUTPUT_ENABLE_ADDR |=>
         second_data_output_pin_en == $past(reg_wdata[SECOND_OUT_BIT]))
      else $error("second output enable did not follow the write");

   ref_readback_a: assert property (
      reg_rd && reg_addr == REFERENCE_SOURCE_ADDR |=>
         reg_rdata == {31'h0, reference_source})
      else $error("reference source read back wrong");

   reserve_one_read_a: assert property (
      reg_rd && reg_addr == FIRST_RESERVE_ADDR |=>
         reg_rdata == {30'h0, first_reserve})
      else $error("first reserve read back wrong");

   reserve_two_read_a: assert property (
      reg_rd && reg_addr == SECOND_RESERVE_ADDR |=>
         reg_rdata == {30'h0, second_reserve})
      else $error("second reserve read back wrong");

   avg_off_a: assert property (
      reg_wr && reg_addr == FIRST_AVERAGE_ADDR && wr_kind == avg_kind_off |=>
         first_average_code == AVG_CODE_OFF)
      else $error("averaging off not stored");

   avg_auto_a: assert property (
      reg_wr && reg_addr == FIRST_AVERAGE_ADDR && wr_kind == avg_kind_auto |=>
         first_average_code == AVG_CODE_AUTO)
      else $error("averaging auto not stored");

   avg_refuse_a: assert property (
      reg_wr && reg_addr == FIRST_AVERAGE_ADDR && wr_kind == avg_kind_bad |=>
         $stable(first_average_code) && write_rejected)
      else $error("refused averaging kind was stored or not flagged");

   avg_milli_a: assert property (
      reg_wr && reg_addr == FIRST_AVERAGE_ADDR && wr_kind == avg_kind_time &&
         wr_suffix == suffix_milli && reg_wdata[27:0] == 28'h0000001 |=>
         first_average_code == AVG_CODE_1MS)
      else $error("milli suffix not scaled to one millisecond");

   slope_store_a: assert property (
      reg_wr && reg_addr == FIRST_SLOPE_ADDR && legal_slope(wr_slope) |=>
         first_filter_slope == $past(wr_slope))
      else $error("legal slope was not stored");

   reject_clear_a: assert property (
      reg_wr && reg_addr == STATUS_ADDR && reg_wdata[REJECT_BIT] |=> !write_rejected)
      else $error("refusal flag did not clear");

   rdata_idle_a: assert property (
      !reg_rd |=> reg_rdata == 32'h00000000)
      else $error("read data not zero outside a read");

   settings_hold_a: assert property (
      !reg_wr |=> $stable(first_data_output_pin_en) && $stable(second_data_output_pin_en) &&
         $stable(reference_source) && $stable(first_reserve) && $stable(second_reserve) &&
         $stable(first_average_code) && $stable(first_filter_slope))
      else $error("a setting changed without a write");

endmodule
`default_nettype wire

// ---- tb/settings_host_model.sv ----
// Host model that issues one-cycle register writes and reads.
`timescale 1ns/10ps
`default_nettype none
module settings_host_model
   import lockin_settings_pkg::*;
(
   // Clock.
   input wire logic core_clk,
   // Register port toward the decoder.
   output logic [7:0] reg_addr,
   output logic [31:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [31:0] reg_rdata
);
   // The bus starts idle.
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 32'h00000000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end

   // Write strobe for one cycle; the strobe stays up so writes can follow back to back.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      reg_rd <= 1'b0;
      @(posedge core_clk);
   endtask

   // Read strobe, then the data taken in the one cycle where it stands.
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      reg_addr <= a;
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~reg_wdata;
      @(negedge core_clk);
      d = reg_rdata;
      @(posedge core_clk);
   endtask

   // Picks the reserve level from the expected noise.
   function automatic reserve_t reserve_for_noise(input logic noisy);
      return noisy ? reserve_level_high : reserve_level_lower;
   endfunction
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the settings decoder against a behavioural model.
`timescale 1ns/10ps
`default_nettype none
module tb
   import lockin_settings_pkg::*;
;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rv;
   logic reg_wr, reg_rd, first_data_output_pin_en, second_data_output_pin_en;
   logic reference_source, write_rejected;
   logic [1:0] first_reserve, second_reserve;
   logic [4:0] first_average_code;
   logic [7:0] first_filter_slope;
   int miscompares = 0;
   int samples_checked = 0;
   int m_en, m_ref, m_res1, m_res2, m_avg, m_slope, m_rej;
   int am[11] = '{3, 4, 7, 15, 0, 200, 100, 500, 1, 1000, 1};
   logic [1:0] asf[11] = '{2'h2, 2'h2, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h2, 2'h1};
   int sl[6] = '{6, 7, 12, 0, 18, 24};

   // 200 MHz clock.
   always #2.5 core_clk = ~core_clk;

   settings_host_model host_u (.core_clk(core_clk), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

   lockin_setting_command_decoder dut_u (.core_clk(core_clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .first_data_output_pin_en(first_data_output_pin_en),
      .second_data_output_pin_en(second_data_output_pin_en),
      .reference_source(reference_source), .first_reserve(first_reserve),
      .second_reserve(second_reserve), .first_average_code(first_average_code),
      .first_filter_slope(first_filter_slope), .write_rejected(write_rejected));

   // Compares one value and counts it.
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask

   // Length of step k in microseconds.
   function automatic longint step(input int k);
      longint p = 1;
      repeat (k / 3) p = p * 10;
      return (k % 3 == 0) ? p : (k % 3 == 1) ? 2 * p : 5 * p;
   endfunction

   // Nearest step token; a tie goes to the longer step.
   function automatic int near_code(input longint us);
      int idx = 0;
      for (int k = 0; k < 24; k++) begin
         if (2 * us >= step(k) + step(k + 1)) begin
            idx = k + 1;
         end
      end
      return 2 + idx;
   endfunction

   // Model state after reset.
   task automatic mreset;
      m_en = OUT_ENABLE_RESET;
      m_ref = REF_RESET;
      m_res1 = RESERVE_RESET;
      m_res2 = RESERVE_RESET;
      m_avg = AVG_RESET;
      m_slope = SLOPE_RESET;
      m_rej = 0;
   endtask

   // Writes one register and updates the model the same way.
   task automatic bw(input logic [7:0] a, input logic [31:0] d);
      longint sc;
      host_u.wr(a, d);
      sc = (d[29:28] == 2'h1) ? 1000 : (d[29:28] == 2'h0) ? 1000000 : 1;
      case (a)
         OUTPUT_ENABLE_ADDR: m_en = d[1:0];
         REFERENCE_SOURCE_ADDR: m_ref = d[0];
         FIRST_RESERVE_ADDR: m_res1 = d[1:0];
         SECOND_RESERVE_ADDR: m_res2 = d[1:0];
         FIRST_AVERAGE_ADDR: begin
            if (d[31:30] == 2'h3 || (d[31:30] == 2'h2 && d[29:28] == 2'h3))
               m_rej = 1;
            else
               m_avg = (d[31:30] == 2'h2) ? near_code(d[27:0] * sc) : d[31:30];
         end
         FIRST_SLOPE_ADDR: begin
            if (d[7:0] inside {8'h06, 8'h0C, 8'h12, 8'h18})
               m_slope = d[7:0];
            else
               m_rej = 1;
         end
         STATUS_ADDR: begin
            if (d[0])
               m_rej = 0;
         end
         default: ;
      endcase
   endtask

   // Expected read word of one address.
   function automatic logic [31:0] exp_word(input logic [7:0] a);
      case (a)
         OUTPUT_ENABLE_ADDR: return m_en;
         REFERENCE_SOURCE_ADDR: return m_ref;
         FIRST_RESERVE_ADDR: return m_res1;
         SECOND_RESERVE_ADDR: return m_res2;
         FIRST_AVERAGE_ADDR: return m_avg;
         FIRST_SLOPE_ADDR: return m_slope;
         STATUS_ADDR: return m_rej;
         default: return 32'h00000000;
      endcase
   endfunction

   // Reads every address, the unmapped one too, and checks the setting outputs.
   task automatic verify;
      for (int a = 0; a < 32; a += 4) begin
         host_u.rd(8'(a), rv);
         chk("read word", rv, exp_word(8'(a)));
      end
      chk("first enable", first_data_output_pin_en, m_en % 2);
      chk("second enable", second_data_output_pin_en, m_en / 2);
      chk("reference", reference_source, m_ref);
      chk("first reserve", first_reserve, m_res1);
      chk("second reserve", second_reserve, m_res2);
      chk("average code", first_average_code, m_avg);
      chk("slope", first_filter_slope, m_slope);
      chk("rejected", write_rejected, m_rej);
      @(negedge core_clk);
      chk("idle read word", reg_rdata, 32'h00000000);
      @(posedge core_clk);
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic test_done;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Cuts a hung run short.
   initial begin
      repeat (100000) @(posedge core_clk);
      miscompares++;
      test_done;
   end

   // Main sequence.
   initial begin
      logic [7:0] a;
      void'($urandom(32'hDF5EE3E4));
      mreset;
      repeat (12) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      verify;
      $display("test reset values finished");
      for (int i = 0; i < 4; i++) begin
         bw(OUTPUT_ENABLE_ADDR, 32'(i));
         bw(FIRST_RESERVE_ADDR, 32'(i));
         bw(SECOND_RESERVE_ADDR, 32'(3 - i));
         bw(REFERENCE_SOURCE_ADDR, 32'(i % 2));
         verify;
      end
      bw(FIRST_RESERVE_ADDR, 32'(host_u.reserve_for_noise(1'b0)));
      verify;
      $display("test enables reference reserves finished");
      bw(FIRST_AVERAGE_ADDR, 32'h40000000);
      verify;
      bw(FIRST_AVERAGE_ADDR, 32'h00000000);
      verify;
      for (int i = 0; i < 11; i++) begin
         bw(FIRST_AVERAGE_ADDR, {2'h2, asf[i], 28'(am[i])});
         verify;
      end
      $display("test averaging time finished");
      for (int i = 0; i < 6; i++) begin
         bw(FIRST_SLOPE_ADDR, 32'(sl[i]));
         verify;
      end
      bw(FIRST_AVERAGE_ADDR, 32'hC0000005);
      bw(FIRST_AVERAGE_ADDR, 32'hB0000005);
      verify;
      bw(STATUS_ADDR, 32'h00000001);
      verify;
      $display("test slopes and refusals finished");
      repeat (60) begin
         a = 8'(($urandom % 9) * 4);
         bw(a, (a == FIRST_AVERAGE_ADDR) ? $urandom : ($urandom % 256));
         if ($urandom % 2)
            verify;
      end
      verify;
      $display("test random traffic finished");
      bw(OUTPUT_ENABLE_ADDR, 32'h00000003);
      verify;
      sys_rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      mreset;
      verify;
      $display("test second reset finished");
      test_done;
   end
endmodule
`default_nettype wire
